// ### logic/pdps_cfgmem.sv
// eight-byte configuration store with registered read data
// assumes pwr_init is raised once at power-up; SYS_RST leaves the contents alone
`timescale 1ns/1ps
module pdps_cfgmem
	import pdps_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       pwr_init,
	input  wire logic [2:0] addr,
	input  wire logic       we,
	input  wire logic [7:0] wdata,
	output logic      [7:0] rdata
);

	typedef struct packed {
		logic [7:0][7:0] mem;
		logic [7:0]      rd;
	} pdps_mem_t;

	pdps_mem_t m_q;
	pdps_mem_t m_d;

	always_comb begin
		m_d    = m_q;
		m_d.rd = m_q.mem[addr];
		if (we) begin
			m_d.mem[addr] = wdata;
		end
	end

	// storage survives core reset, so only the power-up init clears it
	always_ff @(posedge clk) begin
		if (pwr_init) begin
			m_q          <= '0;
			m_q.mem[PDPS_CFG_IDX_MAIN] <= PDPS_CFG_RESET;
			// reset latch may sample right after init drops, so show the init byte now
			m_q.rd       <= PDPS_CFG_RESET;
		end else begin
			m_q <= m_d;
		end
	end

	assign rdata = m_q.rd;

endmodule : pdps_cfgmem

// ### logic/pdps_pkg.sv
// constants, field positions and types for the program and debug port selector
// assumes a 50 MHz core clock and an apb slave with 32-bit data
package pdps_pkg;

	localparam logic [7:0]  PDPS_ADDR_CTRL    = 8'h00;
	localparam logic [7:0]  PDPS_ADDR_STATUS  = 8'h04;
	localparam logic [7:0]  PDPS_ADDR_CFG     = 8'h08;

	localparam int          PDPS_CTRL_OUT     = 0;
	localparam int          PDPS_CTRL_OE      = 1;
	localparam int          PDPS_ST_CLR_WR    = 8;
	localparam int          PDPS_ST_CLR_ER    = 9;

	localparam logic [2:0]  PDPS_CFG_IDX_MAIN = 3'h0;
	localparam int          PDPS_CFGB_DPS     = 0;
	localparam int          PDPS_CFGB_SSE     = 1;
	localparam int          PDPS_CFGB_DBGN    = 2;
	localparam logic [7:0]  PDPS_CFG_RESET    = 8'h06;

	localparam logic [3:0]  PDPS_CMD_WRITE    = 4'h1;
	localparam logic [3:0]  PDPS_CMD_READ     = 4'h2;
	localparam logic [3:0]  PDPS_CMD_BLK_ER   = 4'h3;
	localparam logic [3:0]  PDPS_CMD_ROW_ER   = 4'h4;

	localparam int          PDPS_FRAME_BITS   = 20;
	localparam logic [4:0]  PDPS_FRAME_LAST   = 5'h13;
	localparam logic [3:0]  PDPS_RD_BITS      = 4'h8;
	localparam int          PDPS_SYNC_W       = 10;

	typedef enum logic [2:0] {
		PDPS_M_LOAD  = 3'b000,
		PDPS_M_RUN   = 3'b001,
		PDPS_M_HV    = 3'b010,
		PDPS_M_LV    = 3'b011,
		PDPS_M_HVDED = 3'b100
	} pdps_mode_t;

endpackage : pdps_pkg

// ### logic/pdps_sync.sv
// two-flop synchroniser for a bundle of pin levels
// assumes each bit is an independent slow level or a link clock well below SYS_CLK
`timescale 1ns/1ps
module pdps_sync
	import pdps_pkg::*;
#(
	parameter int W = PDPS_SYNC_W
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);

	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] stable;
	} pdps_sync_t;

	pdps_sync_t s_q;
	pdps_sync_t s_d;

	always_comb begin
		s_d        = s_q;
		s_d.meta   = din;
		s_d.stable = s_q.meta;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign dout = s_q.stable;

endmodule : pdps_sync

// ### logic/pdps_top.sv
// program and debug port selector: legacy/dedicated link routing, entry qualification
// assumes SYS_CLK at 50 MHz, pins asynchronous, apb master on SYS_CLK
//
// How it works
// - dedicated pins carry link traffic only when dedicated_port_select is set.
// - dedicated reset, data, clock pins are separate from general I/O.
// - dedicated port works like legacy: reset/entry, serial clock, bidirectional data.
// - legacy pins keep programming available with dedicated port enabled.
// - high level on legacy reset pin makes dedicated reset pin ignored.
// - dedicated_port_select bit writable only from the legacy port.
// - emulation pin low disables port D, port E, parallel port, enhanced PWM.
// - emulation pin high keeps all large-pinout features enabled.
// - emulation pin counts only with debug enabled and dedicated port selected.
// - single_supply_enable set claims program_entry_pin for entry control.
// - legacy reset high plus program_entry_pin high enters single-supply programming.
// - high-voltage entry on legacy reset always works regardless of single_supply_enable.
// - single_supply_enable changes only under high-voltage programming.
// - single_supply_enable clear frees program_entry_pin, leaves high-voltage entry only.
// - unprotected memory erases by block or row; protected needs block erase.
// - debugger enabled only when the debug bit is zero.
`timescale 1ns/1ps
module pdps_top
	import pdps_pkg::*;
(
	input  wire logic        SYS_CLK,
	input  wire logic        SYS_RST,
	input  wire logic        PWR_INIT,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [7:0]  PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	input  wire logic        LEG_HVL_I,
	input  wire logic        LEG_RLVL_I,
	input  wire logic        LEG_CLK_I,
	input  wire logic        LEG_DAT_I,
	output logic             LEG_DAT_O,
	output logic             LEG_DAT_OE,
	input  wire logic        DED_HVL_I,
	input  wire logic        DED_CLK_I,
	input  wire logic        DED_DAT_I,
	output logic             DED_DAT_O,
	output logic             DED_DAT_OE,
	input  wire logic        ENT_PIN_I,
	output logic             ENT_PIN_O,
	output logic             ENT_PIN_OE,
	input  wire logic        EMU_SEL_I,
	input  wire logic        CODE_PROTECT,
	output logic             PROG_MODE,
	output logic             DEBUG_EN,
	output logic             LEG_LINK_BUSY,
	output logic             PORTD_EN,
	output logic             PORTE_EN,
	output logic             PPORT_EN,
	output logic             ECCP_EN,
	output logic             BLOCK_ERASE,
	output logic             ROW_ERASE,
	output logic      [7:0]  ROW_ADDR
);

	////////////////////////////////////////////////////////////////////////////////
	// state

	typedef struct packed {
		pdps_mode_t  mode;
		logic        dps;
		logic        sse;
		logic        dbgn;
		logic        src_ded;
		logic        clk_prev;
		logic [19:0] shreg;
		logic [4:0]  cnt;
		logic        rd_wait;
		logic        wr_wait;
		logic [7:0]  wr_data;
		logic        rd_act;
		logic [7:0]  rd_data;
		logic [3:0]  rd_cnt;
		logic        dat_o;
		logic        dat_oe;
		logic        ctl_out;
		logic        ctl_oe;
		logic        ref_wr;
		logic        ref_er;
		logic        blk_er;
		logic        row_er;
		logic [7:0]  row_addr;
		logic        mem_we;
		logic [2:0]  mem_addr;
		logic [7:0]  mem_wdata;
		logic        reduced;
		logic [31:0] prdata;
		logic        pslverr;
	} pdps_state_t;

	pdps_state_t s_q;
	pdps_state_t s_d;

	logic [PDPS_SYNC_W-1:0] pins_s;
	logic [7:0]             mem_rdata;
	logic                   leg_hvl;
	logic                   leg_rlvl;
	logic                   leg_clk;
	logic                   leg_dat;
	logic                   ded_hvl;
	logic                   ded_clk;
	logic                   ded_dat;
	logic                   ent_s;
	logic                   emu_s;

	function automatic logic [31:0] pdps_word(input logic [7:0] b);
		pdps_word = {24'h000000, b};
	endfunction : pdps_word

	////////////////////////////////////////////////////////////////////////////////
	// pin synchronisers and config store

	pdps_sync #(
		.W (PDPS_SYNC_W)
	) u_sync (
		.clk  (SYS_CLK),
		.rst  (SYS_RST),
		.din  ({EMU_SEL_I, ENT_PIN_I, DED_DAT_I, DED_CLK_I, DED_HVL_I,
			LEG_DAT_I, LEG_CLK_I, LEG_RLVL_I, LEG_HVL_I, 1'b0}),
		.dout (pins_s)
	);

	assign {emu_s, ent_s, ded_dat, ded_clk, ded_hvl,
		leg_dat, leg_clk, leg_rlvl, leg_hvl} = pins_s[PDPS_SYNC_W-1:1];

	pdps_cfgmem u_mem (
		.clk      (SYS_CLK),
		.pwr_init (PWR_INIT),
		// next address, so read data fits the cycle right after a frame decode
		.addr     (s_d.mem_addr),
		.we       (s_q.mem_we),
		.wdata    (s_q.mem_wdata),
		.rdata    (mem_rdata)
	);

	////////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		logic       hv;
		logic       ded;
		logic       lv;
		logic       prog;
		logic       clk_sel;
		logic       dat_sel;
		logic       rise;
		logic [19:0] fr;
		logic [7:0] merged;
		logic       acc;
		logic       clr_wr;
		logic       clr_er;
		logic       set_wr;
		logic       set_er;
		pdps_mode_t nmode;

		hv      = 1'b0;
		ded     = 1'b0;
		lv      = 1'b0;
		prog    = 1'b0;
		clk_sel = 1'b0;
		dat_sel = 1'b0;
		rise    = 1'b0;
		fr      = '0;
		merged  = '0;
		acc     = 1'b0;
		clr_wr  = 1'b0;
		clr_er  = 1'b0;
		set_wr  = 1'b0;
		set_er  = 1'b0;
		nmode   = s_q.mode;

		s_d        = s_q;
		s_d.mem_we = 1'b0;
		s_d.blk_er = 1'b0;
		s_d.row_er = 1'b0;

		if (s_q.mode == PDPS_M_LOAD) begin
			// store read data already points at the main byte during reset
			s_d.dps  = mem_rdata[PDPS_CFGB_DPS];
			s_d.sse  = mem_rdata[PDPS_CFGB_SSE];
			s_d.dbgn = mem_rdata[PDPS_CFGB_DBGN];
			s_d.mode = PDPS_M_RUN;
		end else begin
			// legacy high level wins over everything else
			hv   = leg_hvl;
			ded  = s_q.dps & ded_hvl & ~hv;
			lv   = s_q.sse & leg_rlvl & ent_s & ~hv & ~ded;
			prog = hv | ded | lv;
			if (hv) begin
				nmode = PDPS_M_HV;
			end else if (ded) begin
				nmode = PDPS_M_HVDED;
			end else if (lv) begin
				nmode = PDPS_M_LV;
			end else begin
				nmode = PDPS_M_RUN;
			end
			s_d.mode    = nmode;
			// debugger outside programming follows the selected port too
			s_d.src_ded = ded | (~prog & ~s_q.dbgn & s_q.dps);
			clk_sel     = s_q.src_ded ? ded_clk : leg_clk;
			dat_sel     = s_q.src_ded ? ded_dat : leg_dat;
			rise        = clk_sel & ~s_q.clk_prev;
			s_d.clk_prev = clk_sel;

			if (nmode != s_q.mode || !prog) begin
				// a mode change drops any partial frame and releases the line
				s_d.cnt     = '0;
				s_d.rd_act  = 1'b0;
				s_d.rd_wait = 1'b0;
				s_d.wr_wait = 1'b0;
				s_d.dat_oe  = 1'b0;
				s_d.clk_prev = s_q.src_ded == s_d.src_ded ? clk_sel : 1'b1;
			end else if (s_q.rd_wait) begin
				s_d.rd_wait = 1'b0;
				s_d.rd_act  = 1'b1;
				s_d.rd_data = mem_rdata;
				s_d.dat_o   = mem_rdata[0];
				s_d.dat_oe  = 1'b1;
				s_d.rd_cnt  = 4'h1;
			end else if (s_q.wr_wait) begin
				s_d.wr_wait = 1'b0;
				merged      = s_q.wr_data;
				if (s_q.mem_addr == PDPS_CFG_IDX_MAIN) begin
					if (s_q.src_ded) begin
						merged[PDPS_CFGB_DPS] = mem_rdata[PDPS_CFGB_DPS];
					end
					if (s_q.mode != PDPS_M_HV && s_q.mode != PDPS_M_HVDED) begin
						merged[PDPS_CFGB_SSE] = mem_rdata[PDPS_CFGB_SSE];
					end
					set_wr = merged != s_q.wr_data;
				end
				s_d.mem_we    = 1'b1;
				s_d.mem_wdata = merged;
			end else if (rise && s_q.rd_act) begin
				if (s_q.rd_cnt == PDPS_RD_BITS) begin
					s_d.rd_act = 1'b0;
					s_d.dat_oe = 1'b0;
				end else begin
					s_d.dat_o  = s_q.rd_data[s_q.rd_cnt[2:0]];
					s_d.rd_cnt = s_q.rd_cnt + 4'h1;
				end
			end else if (rise) begin
				// lsb first: command nibble then data byte then address byte
				fr        = {dat_sel, s_q.shreg[PDPS_FRAME_BITS-1:1]};
				s_d.shreg = fr;
				s_d.cnt   = s_q.cnt + 5'h01;
				if (s_q.cnt == PDPS_FRAME_LAST) begin
					s_d.cnt = '0;
					unique case (fr[3:0])
						PDPS_CMD_WRITE: begin
							s_d.mem_addr = fr[14:12];
							s_d.wr_data  = fr[11:4];
							s_d.wr_wait  = 1'b1;
						end
						PDPS_CMD_READ: begin
							s_d.mem_addr = fr[14:12];
							s_d.rd_wait  = 1'b1;
						end
						PDPS_CMD_BLK_ER: begin
							s_d.blk_er = 1'b1;
						end
						PDPS_CMD_ROW_ER: begin
							// protected rows only go away with a block erase
							s_d.row_er   = ~CODE_PROTECT;
							s_d.row_addr = fr[19:12];
							set_er       = CODE_PROTECT;
						end
						default: begin
							s_d.cnt = '0;
						end
					endcase
				end
			end
		end

		// emulation pin only counts with debugger on and dedicated port chosen
		s_d.reduced = ~s_q.dbgn & s_q.dps & ~emu_s;

		// apb: data registered in setup so the access phase sees a stable word
		if (PSEL && !PENABLE) begin
			s_d.pslverr = 1'b0;
			unique case (PADDR)
				PDPS_ADDR_CTRL: begin
					s_d.prdata = pdps_word({6'h0, s_q.ctl_oe, s_q.ctl_out});
				end
				PDPS_ADDR_STATUS: begin
					s_d.prdata = {22'h0, s_q.ref_er, s_q.ref_wr, s_q.rd_act,
						ent_s & ~s_q.sse, ~s_q.dbgn, s_q.reduced, s_q.src_ded, s_q.mode};
				end
				PDPS_ADDR_CFG: begin
					s_d.prdata = pdps_word({5'h0, s_q.dbgn, s_q.sse, s_q.dps});
				end
				default: begin
					s_d.prdata  = '0;
					s_d.pslverr = 1'b1;
				end
			endcase
		end
		acc = PSEL & PENABLE & PWRITE;
		if (acc && PADDR == PDPS_ADDR_CTRL) begin
			s_d.ctl_out = PWDATA[PDPS_CTRL_OUT];
			s_d.ctl_oe  = PWDATA[PDPS_CTRL_OE];
		end
		if (acc && PADDR == PDPS_ADDR_STATUS) begin
			clr_wr = PWDATA[PDPS_ST_CLR_WR];
			clr_er = PWDATA[PDPS_ST_CLR_ER];
		end
		// a refusal in the clearing cycle still sticks
		s_d.ref_wr = (s_q.ref_wr & ~clr_wr) | set_wr;
		s_d.ref_er = (s_q.ref_er & ~clr_er) | set_er;
	end

	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			s_q          <= '0;
			s_q.mode     <= PDPS_M_LOAD;
			s_q.dbgn     <= 1'b1;
			s_q.mem_addr <= PDPS_CFG_IDX_MAIN;
		end else begin
			s_q <= s_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// outputs

	assign PRDATA        = s_q.prdata;
	assign PREADY        = 1'b1;
	assign PSLVERR       = s_q.pslverr & PSEL & PENABLE;
	// dedicated pins never double as general I/O
	assign DED_DAT_O     = s_q.dat_o;
	assign DED_DAT_OE    = s_q.dat_oe & s_q.src_ded;
	assign LEG_DAT_O     = s_q.dat_o;
	assign LEG_DAT_OE    = s_q.dat_oe & ~s_q.src_ded;
	// while entry control owns the pin, software cannot drive it
	assign ENT_PIN_O     = s_q.ctl_out;
	assign ENT_PIN_OE    = s_q.ctl_oe & ~s_q.sse;
	assign PROG_MODE     = s_q.mode == PDPS_M_HV || s_q.mode == PDPS_M_HVDED
		|| s_q.mode == PDPS_M_LV;
	assign DEBUG_EN      = ~s_q.dbgn;
	assign LEG_LINK_BUSY = ~s_q.src_ded & (PROG_MODE | ~s_q.dbgn);
	assign PORTD_EN      = ~s_q.reduced;
	assign PORTE_EN      = ~s_q.reduced;
	assign PPORT_EN      = ~s_q.reduced;
	assign ECCP_EN       = ~s_q.reduced;
	assign BLOCK_ERASE   = s_q.blk_er;
	assign ROW_ERASE     = s_q.row_er;
	assign ROW_ADDR      = s_q.row_addr;

endmodule : pdps_top

// ### verif/pdps_checker.sv
// pin-level assertions for the port selector: entry, routing, feature gates, erase
// assumes binding into pdps_top, one clock, synchronous active-high SYS_RST
`timescale 1ns/1ps
module pdps_checker (
	input wire logic SYS_CLK,
	input wire logic SYS_RST,
	input wire logic EMU_SEL_I,
	input wire logic LEG_HVL_I,
	input wire logic CODE_PROTECT,
	input wire logic PROG_MODE,
	input wire logic DEBUG_EN,
	input wire logic LEG_LINK_BUSY,
	input wire logic LEG_DAT_OE,
	input wire logic DED_DAT_OE,
	input wire logic PORTD_EN,
	input wire logic PORTE_EN,
	input wire logic PPORT_EN,
	input wire logic ECCP_EN,
	input wire logic BLOCK_ERASE,
	input wire logic ROW_ERASE
);
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (SYS_RST);
	////////////////////////////////////////////////////////////////////////////////
	property p_feat_same;
		PORTD_EN == PORTE_EN && PORTD_EN == PPORT_EN && PORTD_EN == ECCP_EN;
	endproperty
	a_feat_same: assert property (p_feat_same) else $error("feature enables split");
	property p_nodbg_full;
		!DEBUG_EN |-> PORTD_EN;
	endproperty
	a_nodbg_full: assert property (p_nodbg_full) else $error("reduced without debug");
	property p_emu_high;
		EMU_SEL_I [*6] |-> PORTD_EN;
	endproperty
	a_emu_high: assert property (p_emu_high) else $error("reduced with pin high");
	property p_hv_entry;
		LEG_HVL_I [*6] |-> PROG_MODE;
	endproperty
	a_hv_entry: assert property (p_hv_entry) else $error("no high level entry");
	property p_hv_legacy;
		LEG_HVL_I [*6] |-> LEG_LINK_BUSY && !DED_DAT_OE;
	endproperty
	a_hv_legacy: assert property (p_hv_legacy) else $error("dedicated not ignored");
	property p_oe_excl;
		!(LEG_DAT_OE && DED_DAT_OE);
	endproperty
	a_oe_excl: assert property (p_oe_excl) else $error("both data lines driven");
	property p_oe_mode;
		LEG_DAT_OE |-> PROG_MODE || $past(PROG_MODE) || DEBUG_EN;
	endproperty
	a_oe_mode: assert property (p_oe_mode) else $error("data driven while idle");
	property p_cp_row;
		CODE_PROTECT [*3] |-> !ROW_ERASE;
	endproperty
	a_cp_row: assert property (p_cp_row) else $error("protected row erased");
	property p_pulse;
		BLOCK_ERASE || ROW_ERASE |=> !BLOCK_ERASE && !ROW_ERASE;
	endproperty
	a_pulse: assert property (p_pulse) else $error("erase pulse too long");
	// latch lands on the first edge after release, so skip three edges
	property p_cfg_hold;
		!$past(SYS_RST, 3) |-> $stable(DEBUG_EN);
	endproperty
	a_cfg_hold: assert property (p_cfg_hold) else $error("debug enable moved");
endmodule : pdps_checker

bind pdps_top pdps_checker i_chk (.*);

// ### verif/pdps_prog_model.sv
// serial programmer model: 20-bit frames lsb first, 8-bit read back
// assumes the device samples data on rising clock and answers after the frame
`timescale 1ns/1ps
module pdps_prog_model (
	output logic      pclk,
	output logic      pdat,
	input  wire logic din
);
	initial begin
		pclk = 1'h0;
		pdat = 1'h1;
	end
	// clock stands still low outside frames and read-backs
	task automatic frame(input logic [19:0] f);
		#7;
		for (int i = 0; i < 20; i++) begin
			pdat = f[i];
			#80 pclk = 1'h1;
			#80 pclk = 1'h0;
		end
		pdat = ~pdat; // inverted: never a stale level
		#160;
	endtask : frame
	task automatic rd(output logic [7:0] r);
		for (int i = 0; i < 8; i++) begin
			#70 r[i] = din;
			#10 pclk = 1'h1;
			#80 pclk = 1'h0;
		end
		#160;
	endtask : rd
endmodule : pdps_prog_model

// ### verif/tb.sv
// testbench for the port selector: apb access, link frames on both ports, pin entry
// assumes pdps_top, pdps_prog_model and the bound checker are compiled first
`timescale 1ns/1ps
module tb
	import pdps_pkg::*;
;
	logic        SYS_CLK = 1'h0, SYS_RST = 1'h1, PWR_INIT = 1'h1;
	logic        PSEL = 1'h0, PENABLE = 1'h0, PWRITE = 1'h0;
	logic [7:0]  PADDR = 8'h00;
	logic [31:0] PWDATA = 32'h0, PRDATA;
	logic        PREADY, PSLVERR, LEG_DAT_O, LEG_DAT_OE, DED_DAT_O, DED_DAT_OE;
	logic        LEG_HVL_I = 1'h0, LEG_RLVL_I = 1'h0, DED_HVL_I = 1'h0;
	logic        EMU_SEL_I = 1'h1, CODE_PROTECT = 1'h0, ent = 1'h0;
	logic        ENT_PIN_O, ENT_PIN_OE, PROG_MODE, DEBUG_EN, LEG_LINK_BUSY;
	logic        PORTD_EN, PORTE_EN, PPORT_EN, ECCP_EN, BLOCK_ERASE, ROW_ERASE;
	logic [7:0]  ROW_ADDR, row_a, b;
	logic        l_dat, d_dat, er;
	wire         LEG_CLK_I, DED_CLK_I;
	wire         LEG_DAT_I = LEG_DAT_OE ? LEG_DAT_O : l_dat;
	wire         DED_DAT_I = DED_DAT_OE ? DED_DAT_O : d_dat;
	wire         ENT_PIN_I = ENT_PIN_OE ? ENT_PIN_O : ent;
	int          fail_count = 0, checked = 0, cyc = 0, n_blk = 0, n_row = 0;

	pdps_top i_dut (.*);
	pdps_prog_model i_leg (.pclk(LEG_CLK_I), .pdat(l_dat), .din(LEG_DAT_I));
	pdps_prog_model i_ded (.pclk(DED_CLK_I), .pdat(d_dat), .din(DED_DAT_I));
	always #10 SYS_CLK = ~SYS_CLK;
	always @(posedge SYS_CLK) begin
		cyc++;
		if (BLOCK_ERASE === 1'h1)
			n_blk++;
		if (ROW_ERASE === 1'h1) begin
			n_row++;
			row_a = ROW_ADDR;
		end
		if (cyc == 10000) begin
			fail_count++;
			give_verdict();
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic give_verdict();
		if (fail_count == 0 && checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : give_verdict
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wt(input int n);
		repeat (n) @(posedge SYS_CLK);
	endtask : wt
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
			output logic [31:0] rd, output logic e);
		PSEL <= 1'h1;
		PENABLE <= 1'h0;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= wd;
		@(posedge SYS_CLK);
		PENABLE <= 1'h1;
		do @(posedge SYS_CLK); while (PREADY !== 1'h1);
		rd = PRDATA;
		e = PSLVERR;
		PSEL <= 1'h0;
		PENABLE <= 1'h0;
		@(posedge SYS_CLK);
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		apb(1'h1, a, d, x, er);
	endtask : wr
	task automatic rg(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x,
			input logic xe);
		logic [31:0] d;
		apb(1'h0, a, 32'h0, d, er);
		chk(d & m, x);
		chk(er, xe);
	endtask : rg
	// the wait after each frame keeps pin changes clear of the answer
	task automatic lnk(input logic ded, input logic [3:0] c, input logic [7:0] d,
			input logic [7:0] a, output logic [7:0] r);
		if (ded) begin
			i_ded.frame({a, d, c});
			if (c == PDPS_CMD_READ)
				i_ded.rd(r);
		end else begin
			i_leg.frame({a, d, c});
			if (c == PDPS_CMD_READ)
				i_leg.rd(r);
		end
		@(posedge SYS_CLK);
	endtask : lnk
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		wt(3);
		SYS_RST <= 1'h0;
		PWR_INIT <= 1'h0;
		wt(1);
		rg(PDPS_ADDR_CFG, 32'hFF, 32'h06, 1'h0);
		rg(8'h0C, 32'hFFFFFFFF, 32'h0, 1'h1);
		chk(DEBUG_EN, 1'h0);
		wr(PDPS_ADDR_CTRL, 32'h3);
		EMU_SEL_I <= 1'h0;
		wt(6);
		chk(ENT_PIN_OE, 1'h0);
		chk(PORTD_EN, 1'h1);
		LEG_RLVL_I <= 1'h1;
		ent <= 1'h1;
		wt(6);
		rg(PDPS_ADDR_STATUS, 32'h7, 32'h3, 1'h0);
		lnk(1'h0, PDPS_CMD_WRITE, 8'h05, 8'h00, b);
		rg(PDPS_ADDR_STATUS, 32'h100, 32'h100, 1'h0);
		lnk(1'h0, PDPS_CMD_READ, 8'h00, 8'h00, b);
		chk(b, 8'h07);
		wr(PDPS_ADDR_STATUS, 32'h100);
		rg(PDPS_ADDR_STATUS, 32'h100, 32'h0, 1'h0);
		ent <= 1'h0;
		LEG_HVL_I <= 1'h1;
		wt(6);
		rg(PDPS_ADDR_STATUS, 32'h7, 32'h2, 1'h0);
		chk(LEG_LINK_BUSY, 1'h1);
		lnk(1'h0, PDPS_CMD_WRITE, 8'h01, 8'h00, b);
		lnk(1'h0, PDPS_CMD_READ, 8'h00, 8'h00, b);
		chk(b, 8'h01);
		SYS_RST <= 1'h1;
		LEG_HVL_I <= 1'h0;
		EMU_SEL_I <= 1'h1;
		wt(3);
		SYS_RST <= 1'h0;
		wt(1);
		rg(PDPS_ADDR_CFG, 32'hFF, 32'h01, 1'h0);
		chk(DEBUG_EN, 1'h1);
		wr(PDPS_ADDR_CTRL, 32'h3);
		wt(6);
		chk(ENT_PIN_OE, 1'h1);
		chk(ENT_PIN_O, 1'h1);
		rg(PDPS_ADDR_STATUS, 32'hF, 32'h9, 1'h0);
		wr(PDPS_ADDR_CTRL, 32'h0);
		EMU_SEL_I <= 1'h0;
		wt(6);
		chk({PORTD_EN, PORTE_EN, PPORT_EN, ECCP_EN}, 4'h0);
		EMU_SEL_I <= 1'h1;
		wt(6);
		chk({PORTD_EN, PORTE_EN, PPORT_EN, ECCP_EN}, 4'hF);
		DED_HVL_I <= 1'h1;
		wt(6);
		rg(PDPS_ADDR_STATUS, 32'hF, 32'hC, 1'h0);
		lnk(1'h1, PDPS_CMD_WRITE, 8'h00, 8'h00, b);
		rg(PDPS_ADDR_STATUS, 32'h100, 32'h100, 1'h0);
		lnk(1'h1, PDPS_CMD_READ, 8'h00, 8'h00, b);
		chk(b, 8'h01);
		LEG_HVL_I <= 1'h1;
		wt(6);
		rg(PDPS_ADDR_STATUS, 32'hF, 32'h2, 1'h0);
		CODE_PROTECT <= 1'h1;
		lnk(1'h0, PDPS_CMD_ROW_ER, 8'h00, 8'h05, b);
		rg(PDPS_ADDR_STATUS, 32'h200, 32'h200, 1'h0);
		lnk(1'h0, PDPS_CMD_BLK_ER, 8'h00, 8'h00, b);
		CODE_PROTECT <= 1'h0;
		lnk(1'h0, PDPS_CMD_ROW_ER, 8'h00, 8'h05, b);
		chk(n_blk, 1);
		chk(n_row, 1);
		chk(row_a, 8'h05);
		give_verdict();
	end
endmodule : tb
